// ==== core/iqmap_regs.sv ====
// apb register bank for iq mapping, table and frame offset configuration
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module iqmap_regs
    import iqmap_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // clocking option strap
    input wire logic INTERNAL_CLOCKED,
    // mapping mode outputs
    output logic [1:0] MAP_MODE,
    output logic RX_SYNC_BUFFER_MODE,
    output logic TX_SYNC_BUFFER_MODE,
    output logic NARROW_SAMPLE_SELECT,
    output logic [4:0] ACTIVE_CHANNEL_COUNT,
    output logic [4:0] CHANNEL_OVERSAMPLING_FACTOR,
    output logic [7:0] CONTAINER_FRAMES,
    output logic TABLE_GEOMETRY_USED,
    // table lookup port for the mapping datapath
    input wire logic [10:0] RX_TABLE_ADDR,
    input wire logic [10:0] TX_TABLE_ADDR,
    output logic [31:0] RX_TABLE_ENTRY,
    output logic [31:0] TX_TABLE_ENTRY,
    // buffer frame offsets
    output logic RX_BUFFER_OFFSET_ACTIVE,
    output logic RX_BUFFER_PER_HYPERFRAME_SYNC,
    output logic [15:0] RX_BUFFER_OFFSET,
    output logic TX_BUFFER_OFFSET_ACTIVE,
    output logic TX_BUFFER_PER_HYPERFRAME_SYNC,
    output logic [15:0] TX_BUFFER_OFFSET,
    // start pulse offsets
    output logic RX_PULSE_OFFSET_ACTIVE,
    output logic RX_PULSE_PER_HYPERFRAME_SYNC,
    output logic [21:0] RX_PULSE_OFFSET,
    output logic TX_PULSE_OFFSET_ACTIVE,
    output logic TX_PULSE_PER_HYPERFRAME_SYNC,
    output logic [21:0] TX_PULSE_OFFSET
);

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge(
        input logic [31:0] old_value,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old_value & ~lanes) | (wdata & lanes);
    endfunction : merge

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == MAPPING_FEATURE_CONFIG_ADDR)
            || (addr == BASIC_MAPPING_COUNT_CONFIG_ADDR)
            || (addr == CONTAINER_FRAMES_CONFIG_ADDR)
            || (addr == MAPPING_TABLE_INDEX_ADDR)
            || (addr == MAPPING_TABLE_RX_ENTRY_ADDR)
            || (addr == MAPPING_TABLE_TX_ENTRY_ADDR)
            || (addr == RX_BUFFER_FRAME_OFFSET_ADDR)
            || (addr == TX_BUFFER_FRAME_OFFSET_ADDR)
            || (addr == RX_START_PULSE_OFFSET_ADDR)
            || (addr == TX_START_PULSE_OFFSET_ADDR);
    endfunction : is_mapped

    // ==========================================================
    // strap synchroniser
    logic clocked_meta;
    logic clocked_sync;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            clocked_meta <= 1'b0;
            clocked_sync <= 1'b0;
        end
        else
        begin
            clocked_meta <= INTERNAL_CLOCKED;
            clocked_sync <= clocked_meta;
        end
    end

    // ==========================================================
    // apb handshake: one wait state so read data comes from a flop
    logic commit;
    logic wr_commit;

    assign commit = PSEL && PENABLE && PREADY;
    assign wr_commit = commit && PWRITE && is_mapped(PADDR);

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !is_mapped(PADDR);
        end
    end

    // ==========================================================
    // configuration registers
    logic [31:0] feature_config;
    logic [31:0] basic_mapping_count_config;
    logic [31:0] container_frames_config;
    logic [31:0] mapping_table_index;
    logic [31:0] rx_buffer_frame_offset;
    logic [31:0] tx_buffer_frame_offset;
    logic [31:0] rx_start_pulse_offset;
    logic [31:0] tx_start_pulse_offset;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            feature_config <= REG_RESET;
            basic_mapping_count_config <= REG_RESET;
            container_frames_config <= REG_RESET;
            mapping_table_index <= REG_RESET;
        end
        else if (wr_commit)
        begin
            // reserved lanes are masked out of every write
            if (PADDR == MAPPING_FEATURE_CONFIG_ADDR)
                feature_config <= merge(feature_config, PWDATA, PSTRB, FEATURE_MASK);
            if (PADDR == BASIC_MAPPING_COUNT_CONFIG_ADDR)
                basic_mapping_count_config <= merge(basic_mapping_count_config,
                    PWDATA, PSTRB, COUNT_MASK);
            if (PADDR == CONTAINER_FRAMES_CONFIG_ADDR)
                container_frames_config <= merge(container_frames_config,
                    PWDATA, PSTRB, CONTAINER_MASK);
            if (PADDR == MAPPING_TABLE_INDEX_ADDR)
                mapping_table_index <= merge(mapping_table_index,
                    PWDATA, PSTRB, INDEX_MASK);
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rx_buffer_frame_offset <= REG_RESET;
            tx_buffer_frame_offset <= REG_RESET;
            rx_start_pulse_offset <= REG_RESET;
            tx_start_pulse_offset <= REG_RESET;
        end
        else if (wr_commit)
        begin
            if (PADDR == RX_BUFFER_FRAME_OFFSET_ADDR)
                rx_buffer_frame_offset <= merge(rx_buffer_frame_offset,
                    PWDATA, PSTRB, BUF_OFFSET_MASK);
            if (PADDR == TX_BUFFER_FRAME_OFFSET_ADDR)
                tx_buffer_frame_offset <= merge(tx_buffer_frame_offset,
                    PWDATA, PSTRB, BUF_OFFSET_MASK);
            if (PADDR == RX_START_PULSE_OFFSET_ADDR)
                rx_start_pulse_offset <= merge(rx_start_pulse_offset,
                    PWDATA, PSTRB, START_OFFSET_MASK);
            if (PADDR == TX_START_PULSE_OFFSET_ADDR)
                tx_start_pulse_offset <= merge(tx_start_pulse_offset,
                    PWDATA, PSTRB, START_OFFSET_MASK);
        end
    end

    // ==========================================================
    // advanced mapping tables, no reset so they map onto block ram
    logic [31:0] rx_table [TBL_DEPTH];
    logic [31:0] tx_table [TBL_DEPTH];
    logic [31:0] rx_sel_entry;
    logic [31:0] tx_sel_entry;
    logic [10:0] sel_index;

    assign sel_index = mapping_table_index[INDEX_W-1:0];

    // only the indexed entry changes
    always_ff @(posedge CLK)
    begin
        if (wr_commit && PADDR == MAPPING_TABLE_RX_ENTRY_ADDR)
            rx_table[sel_index] <= merge(rx_sel_entry, PWDATA, PSTRB,
                ENTRY_MASK);
        if (wr_commit && PADDR == MAPPING_TABLE_TX_ENTRY_ADDR)
            tx_table[sel_index] <= merge(tx_sel_entry, PWDATA, PSTRB,
                ENTRY_MASK);
    end

    // selected entry refreshed every cycle; the apb wait state covers it
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rx_sel_entry <= REG_RESET;
            tx_sel_entry <= REG_RESET;
        end
        else
        begin
            rx_sel_entry <= rx_table[sel_index] & ENTRY_MASK;
            tx_sel_entry <= tx_table[sel_index] & ENTRY_MASK;
        end
    end

    // datapath lookup port
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RX_TABLE_ENTRY <= REG_RESET;
            TX_TABLE_ENTRY <= REG_RESET;
        end
        else
        begin
            RX_TABLE_ENTRY <= rx_table[RX_TABLE_ADDR] & ENTRY_MASK;
            TX_TABLE_ENTRY <= tx_table[TX_TABLE_ADDR] & ENTRY_MASK;
        end
    end

    // ==========================================================
    // read data
    logic [31:0] rd_value;

    always_comb
    begin
        rd_value = REG_RESET;
        unique case (PADDR)
            MAPPING_FEATURE_CONFIG_ADDR: rd_value = feature_config;
            BASIC_MAPPING_COUNT_CONFIG_ADDR: rd_value = basic_mapping_count_config;
            CONTAINER_FRAMES_CONFIG_ADDR: rd_value = container_frames_config;
            MAPPING_TABLE_INDEX_ADDR: rd_value = mapping_table_index;
            MAPPING_TABLE_RX_ENTRY_ADDR: rd_value = rx_sel_entry;
            MAPPING_TABLE_TX_ENTRY_ADDR: rd_value = tx_sel_entry;
            RX_BUFFER_FRAME_OFFSET_ADDR: rd_value = rx_buffer_frame_offset;
            TX_BUFFER_FRAME_OFFSET_ADDR: rd_value = tx_buffer_frame_offset;
            RX_START_PULSE_OFFSET_ADDR: rd_value = rx_start_pulse_offset;
            TX_START_PULSE_OFFSET_ADDR: rd_value = tx_start_pulse_offset;
            default: rd_value = REG_RESET;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            PRDATA <= REG_RESET;
        else if (PSEL && PENABLE && !PREADY && !PWRITE)
            PRDATA <= rd_value;
    end

    // ==========================================================
    // mode decode
    iqmap_mode_e mode;
    logic basic_mode;
    logic narrow;
    logic rx_sync_buf;
    logic tx_sync_buf;

    assign mode = iqmap_mode_e'(feature_config[MODE_LSB +: 2]);
    assign basic_mode = (mode == MAP_BASIC);
    assign narrow = feature_config[NARROW_BIT];
    // sync mode bits only count when the core is not internally clocked
    assign rx_sync_buf = feature_config[RX_SYNC_BIT] && !clocked_sync;
    assign tx_sync_buf = feature_config[TX_SYNC_BIT] && !clocked_sync;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            MAP_MODE <= MAP_BASIC;
            RX_SYNC_BUFFER_MODE <= 1'b0;
            TX_SYNC_BUFFER_MODE <= 1'b0;
            NARROW_SAMPLE_SELECT <= 1'b0;
            ACTIVE_CHANNEL_COUNT <= 5'h0;
            CHANNEL_OVERSAMPLING_FACTOR <= 5'h0;
            CONTAINER_FRAMES <= 8'h0;
            TABLE_GEOMETRY_USED <= 1'b0;
        end
        else
        begin
            MAP_MODE <= mode;
            RX_SYNC_BUFFER_MODE <= rx_sync_buf;
            TX_SYNC_BUFFER_MODE <= tx_sync_buf;
            NARROW_SAMPLE_SELECT <= narrow;
            // basic counts zeroed outside mode 00
            ACTIVE_CHANNEL_COUNT <= basic_mode
                ? basic_mapping_count_config[CHAN_COUNT_LSB +: 5] : 5'h0;
            CHANNEL_OVERSAMPLING_FACTOR <= basic_mode
                ? basic_mapping_count_config[OVERSAMPLE_LSB +: 5] : 5'h0;
            CONTAINER_FRAMES <= basic_mode
                ? 8'h0 : container_frames_config[CONTAINER_W-1:0];
            // mode 10/11 in 15-bit sampling rely on software-fixed values
            TABLE_GEOMETRY_USED <= !basic_mode && (!narrow || mode == MAP_ADV_SAMPLE);
        end
    end

    // ==========================================================
    // frame offsets; hyperframe field dropped under per-hyperframe sync
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RX_BUFFER_OFFSET_ACTIVE <= 1'b0;
            RX_BUFFER_PER_HYPERFRAME_SYNC <= 1'b0;
            RX_BUFFER_OFFSET <= 16'h0;
            TX_BUFFER_OFFSET_ACTIVE <= 1'b0;
            TX_BUFFER_PER_HYPERFRAME_SYNC <= 1'b0;
            TX_BUFFER_OFFSET <= 16'h0;
        end
        else
        begin
            // fifo mode leaves buffer offsets unused
            RX_BUFFER_OFFSET_ACTIVE <= rx_sync_buf;
            TX_BUFFER_OFFSET_ACTIVE <= tx_sync_buf;
            RX_BUFFER_PER_HYPERFRAME_SYNC <= rx_buffer_frame_offset[BUF_RESYNC_BIT];
            TX_BUFFER_PER_HYPERFRAME_SYNC <= tx_buffer_frame_offset[BUF_RESYNC_BIT];
            RX_BUFFER_OFFSET <= rx_buffer_frame_offset[BUF_RESYNC_BIT]
                ? {8'h0, rx_buffer_frame_offset[7:0]}
                : rx_buffer_frame_offset[15:0];
            TX_BUFFER_OFFSET <= tx_buffer_frame_offset[BUF_RESYNC_BIT]
                ? {8'h0, tx_buffer_frame_offset[7:0]}
                : tx_buffer_frame_offset[15:0];
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RX_PULSE_OFFSET_ACTIVE <= 1'b0;
            RX_PULSE_PER_HYPERFRAME_SYNC <= 1'b0;
            RX_PULSE_OFFSET <= 22'h0;
            TX_PULSE_OFFSET_ACTIVE <= 1'b0;
            TX_PULSE_PER_HYPERFRAME_SYNC <= 1'b0;
            TX_PULSE_OFFSET <= 22'h0;
        end
        else
        begin
            // inert in fifo or internally clocked mode
            RX_PULSE_OFFSET_ACTIVE <= rx_sync_buf;
            TX_PULSE_OFFSET_ACTIVE <= tx_sync_buf;
            RX_PULSE_PER_HYPERFRAME_SYNC <= rx_start_pulse_offset[PULSE_RESYNC_BIT];
            TX_PULSE_PER_HYPERFRAME_SYNC <= tx_start_pulse_offset[PULSE_RESYNC_BIT];
            RX_PULSE_OFFSET <= rx_start_pulse_offset[PULSE_RESYNC_BIT]
                ? {rx_start_pulse_offset[21:16], 8'h0, rx_start_pulse_offset[7:0]}
                : rx_start_pulse_offset[21:0];
            TX_PULSE_OFFSET <= tx_start_pulse_offset[PULSE_RESYNC_BIT]
                ? {tx_start_pulse_offset[21:16], 8'h0, tx_start_pulse_offset[7:0]}
                : tx_start_pulse_offset[21:0];
        end
    end

    // ordering of buffer and start offsets is left to software

endmodule : iqmap_regs

`default_nettype wire

// ==== core/iqmap_pkg.sv ====
// constants for the iq mapping and frame offset configuration register bank
// Contract
// - count register bits 12:8 hold active channel count, reset zero.
// - count register bits 4:0 hold oversampling factor, reset zero.
// - count and oversampling act only in basic mapping mode 00.
// - container frame count field, advanced modes only, resets zero.
// - 11-bit table index selects the exposed rx and tx table entry.
// - table entry bits 28:24 hold half the sample bit width.
// - table entry bits 20:16 hold half the sample start position.
// - width and position honoured in 15-bit mode only for mode 01.
// - entry holds carrier interface number from bit 8, enable at bit 0.
// - rx buffer offset holds hyperframe 15:8 and basic frame 7:0.
// - tx buffer offset holds hyperframe and basic frame for buffer reads.
// - rx start offset holds sequence 21:16 plus hyperframe and basic frame.
// - tx start offset likewise fixes the tx start pulse.
// - resync bit 16 or 24 means per-hyperframe sync, hyperframe ignored.
// - buffer offsets inert while the path runs in fifo mode.
// - start offsets inert in fifo mode or internally clocked mode.
// - two-bit mapping mode: 00 basic, 01 10 11 advanced.
// - rx and tx sync mode bits: 0 fifo, 1 synchronous buffer.
// - sample width bit: 0 gives 16-bit, 1 gives 15-bit samples.
package iqmap_pkg;

    // ==========================================================
    // sizes
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned INDEX_W = 11;
    localparam int unsigned TBL_DEPTH = 2048;
    localparam int unsigned CONTAINER_W = 8;
    localparam int unsigned CARRIER_W = 5;

    // ==========================================================
    // register byte offsets
    localparam logic [11:0] MAPPING_FEATURE_CONFIG_ADDR = 12'h100;
    localparam logic [11:0] BASIC_MAPPING_COUNT_CONFIG_ADDR = 12'h104;
    localparam logic [11:0] CONTAINER_FRAMES_CONFIG_ADDR = 12'h108;
    localparam logic [11:0] MAPPING_TABLE_INDEX_ADDR = 12'h10c;
    localparam logic [11:0] MAPPING_TABLE_RX_ENTRY_ADDR = 12'h110;
    localparam logic [11:0] MAPPING_TABLE_TX_ENTRY_ADDR = 12'h114;
    localparam logic [11:0] RX_BUFFER_FRAME_OFFSET_ADDR = 12'h118;
    localparam logic [11:0] TX_BUFFER_FRAME_OFFSET_ADDR = 12'h11c;
    localparam logic [11:0] RX_START_PULSE_OFFSET_ADDR = 12'h120;
    localparam logic [11:0] TX_START_PULSE_OFFSET_ADDR = 12'h124;

    // ==========================================================
    // writable bit masks, everything else reads zero
    localparam logic [31:0] FEATURE_MASK = 32'h0000001f;
    localparam logic [31:0] COUNT_MASK = 32'h00001f1f;
    localparam logic [31:0] CONTAINER_MASK = 32'h000000ff;
    localparam logic [31:0] INDEX_MASK = 32'h000007ff;
    localparam logic [31:0] ENTRY_MASK = 32'h1f1f1f01;
    localparam logic [31:0] BUF_OFFSET_MASK = 32'h0001ffff;
    localparam logic [31:0] START_OFFSET_MASK = 32'h013fffff;
    localparam logic [31:0] REG_RESET = 32'h00000000;

    // ==========================================================
    // field positions
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned RX_SYNC_BIT = 2;
    localparam int unsigned TX_SYNC_BIT = 3;
    localparam int unsigned NARROW_BIT = 4;
    localparam int unsigned CHAN_COUNT_LSB = 8;
    localparam int unsigned OVERSAMPLE_LSB = 0;
    localparam int unsigned BUF_RESYNC_BIT = 16;
    localparam int unsigned PULSE_RESYNC_BIT = 24;
    localparam int unsigned HYPERFRAME_LSB = 8;

    // ==========================================================
    // mapping modes
    typedef enum logic [1:0] {
        MAP_BASIC = 2'b00,
        MAP_ADV_SAMPLE = 2'b01,
        MAP_ADV_COMPAT = 2'b10,
        MAP_ADV_LEGACY = 2'b11
    } iqmap_mode_e;

endpackage : iqmap_pkg

// ==== test/iqmap_regs_props.sv ====
// assertion checker for the iq mapping register bank
`timescale 1ns/1ps
`default_nettype none

module iqmap_regs_props
    import iqmap_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // apb handshake
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // configuration
    input wire logic INTERNAL_CLOCKED,
    input wire logic [1:0] MAP_MODE,
    input wire logic RX_SYNC_BUFFER_MODE,
    input wire logic NARROW_SAMPLE_SELECT,
    input wire logic [4:0] ACTIVE_CHANNEL_COUNT,
    input wire logic [4:0] CHANNEL_OVERSAMPLING_FACTOR,
    input wire logic [7:0] CONTAINER_FRAMES,
    input wire logic TABLE_GEOMETRY_USED,
    input wire logic RX_BUFFER_OFFSET_ACTIVE,
    input wire logic RX_BUFFER_PER_HYPERFRAME_SYNC,
    input wire logic [15:0] RX_BUFFER_OFFSET,
    input wire logic TX_PULSE_OFFSET_ACTIVE,
    input wire logic TX_PULSE_PER_HYPERFRAME_SYNC,
    input wire logic [21:0] TX_PULSE_OFFSET
);
    // ==========================================================
    // properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_answer; !PREADY ##1 (PREADY && PSEL && PENABLE); endsequence
    property p_one_wait; s_setup |=> s_answer; endproperty
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    property p_err_with_ready; PSLVERR |-> PREADY; endproperty
    property p_basic_only; MAP_MODE != 2'h0 |->
        ACTIVE_CHANNEL_COUNT == 5'h0 && CHANNEL_OVERSAMPLING_FACTOR == 5'h0; endproperty
    property p_adv_only; MAP_MODE == 2'h0 |-> CONTAINER_FRAMES == 8'h0; endproperty
    property p_geometry; TABLE_GEOMETRY_USED ==
        (MAP_MODE != 2'h0 && (!NARROW_SAMPLE_SELECT || MAP_MODE == 2'h1)); endproperty
    property p_buf_resync; RX_BUFFER_PER_HYPERFRAME_SYNC |-> RX_BUFFER_OFFSET[15:8] == 8'h0;
    endproperty
    property p_pulse_resync; TX_PULSE_PER_HYPERFRAME_SYNC |-> TX_PULSE_OFFSET[15:8] == 8'h0;
    endproperty
    property p_fifo_inert; RX_BUFFER_OFFSET_ACTIVE == RX_SYNC_BUFFER_MODE; endproperty
    property p_internal_inert; INTERNAL_CLOCKED [*5] |-> !TX_PULSE_OFFSET_ACTIVE; endproperty
    a_one_wait: assert property (p_one_wait) else $error("apb answer timing");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_basic_only: assert property (p_basic_only) else $error("basic counts leak");
    a_adv_only: assert property (p_adv_only) else $error("container count leak");
    a_geometry: assert property (p_geometry) else $error("geometry use wrong");
    a_buf_resync: assert property (p_buf_resync) else $error("buffer hf kept");
    a_pulse_resync: assert property (p_pulse_resync) else $error("pulse hf kept");
    a_fifo_inert: assert property (p_fifo_inert) else $error("buffer offset active");
    a_internal_inert: assert property (p_internal_inert) else $error("pulse active");
endmodule : iqmap_regs_props

bind iqmap_regs iqmap_regs_props i_iqmap_regs_props (.CLK(CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INTERNAL_CLOCKED(INTERNAL_CLOCKED), .MAP_MODE(MAP_MODE),
    .RX_SYNC_BUFFER_MODE(RX_SYNC_BUFFER_MODE), .NARROW_SAMPLE_SELECT(NARROW_SAMPLE_SELECT),
    .ACTIVE_CHANNEL_COUNT(ACTIVE_CHANNEL_COUNT), .CONTAINER_FRAMES(CONTAINER_FRAMES),
    .CHANNEL_OVERSAMPLING_FACTOR(CHANNEL_OVERSAMPLING_FACTOR),
    .TABLE_GEOMETRY_USED(TABLE_GEOMETRY_USED), .RX_BUFFER_OFFSET(RX_BUFFER_OFFSET),
    .RX_BUFFER_OFFSET_ACTIVE(RX_BUFFER_OFFSET_ACTIVE), .TX_PULSE_OFFSET(TX_PULSE_OFFSET),
    .RX_BUFFER_PER_HYPERFRAME_SYNC(RX_BUFFER_PER_HYPERFRAME_SYNC),
    .TX_PULSE_OFFSET_ACTIVE(TX_PULSE_OFFSET_ACTIVE),
    .TX_PULSE_PER_HYPERFRAME_SYNC(TX_PULSE_PER_HYPERFRAME_SYNC));
`default_nettype wire

// ==== test/tb.sv ====
// self-checking testbench for the iq mapping register bank
`timescale 1ns/1ps
`default_nettype none

module tb
    import iqmap_pkg::*;
;
    logic clk, sys_rst, psel, penable, pwrite, int_clk, pready, pslverr, narrow, geom, e;
    logic rx_sync, tx_sync, rxb_act, txb_act, rxp_act, txp_act, rxb_hf, txb_hf, rxp_hf, txp_hf;
    logic [1:0] map_mode;
    logic [3:0] pstrb;
    logic [4:0] act_cnt, ovs;
    logic [7:0] cont;
    logic [10:0] rx_ta, tx_ta;
    logic [11:0] paddr;
    logic [15:0] rxb_off, txb_off;
    logic [21:0] rxp_off, txp_off;
    logic [31:0] pwdata, prdata, rx_ent, tx_ent, q;
    int bad_count, check_count;
    logic [31:0] masks [10] = '{FEATURE_MASK, COUNT_MASK, CONTAINER_MASK, INDEX_MASK,
        ENTRY_MASK, ENTRY_MASK, BUF_OFFSET_MASK, BUF_OFFSET_MASK, START_OFFSET_MASK,
        START_OFFSET_MASK};

    iqmap_regs i_iqmap_regs (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .INTERNAL_CLOCKED(int_clk), .MAP_MODE(map_mode),
        .RX_SYNC_BUFFER_MODE(rx_sync), .TX_SYNC_BUFFER_MODE(tx_sync),
        .NARROW_SAMPLE_SELECT(narrow), .ACTIVE_CHANNEL_COUNT(act_cnt),
        .CHANNEL_OVERSAMPLING_FACTOR(ovs), .CONTAINER_FRAMES(cont), .TABLE_GEOMETRY_USED(geom),
        .RX_TABLE_ADDR(rx_ta), .TX_TABLE_ADDR(tx_ta), .RX_TABLE_ENTRY(rx_ent),
        .TX_TABLE_ENTRY(tx_ent), .RX_BUFFER_OFFSET_ACTIVE(rxb_act),
        .RX_BUFFER_PER_HYPERFRAME_SYNC(rxb_hf), .RX_BUFFER_OFFSET(rxb_off),
        .TX_BUFFER_OFFSET_ACTIVE(txb_act), .TX_BUFFER_PER_HYPERFRAME_SYNC(txb_hf),
        .TX_BUFFER_OFFSET(txb_off), .RX_PULSE_OFFSET_ACTIVE(rxp_act),
        .RX_PULSE_PER_HYPERFRAME_SYNC(rxp_hf), .RX_PULSE_OFFSET(rxp_off),
        .TX_PULSE_OFFSET_ACTIVE(txp_act), .TX_PULSE_PER_HYPERFRAME_SYNC(txp_hf),
        .TX_PULSE_OFFSET(txp_off));

    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // bounded wait: a silent slave is counted, not hung on
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        apb(1'b1, a, d, s, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
        apb(1'b0, a, 32'h0, 4'h0, q, e);
        check(q, x);
        check(32'(e), 32'(xe));
    endtask : rd

    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle

    function automatic logic [11:0] addr_of(input int i);
        return MAPPING_FEATURE_CONFIG_ADDR + 12'(4 * i);
    endfunction : addr_of

    // ==========================================================
    // clock, watchdog and tests
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #400000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        {psel, penable, pwrite, int_clk, paddr, pwdata, pstrb, rx_ta, tx_ta} = '0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++)
            if (i != 4 && i != 5)
                rd(addr_of(i), REG_RESET);
        rd(12'h128, 32'h0, 1'b1);
        $display("reset test done");
        for (int i = 1; i < 12; i++)
            wr(addr_of(i % 11), 32'hffffffff);
        for (int i = 0; i < 10; i++)
            rd(addr_of(i), masks[i]);
        rd(12'h128, 32'h0, 1'b1);
        $display("mask test done");
        wr(BASIC_MAPPING_COUNT_CONFIG_ADDR, 32'h00000a05);
        wr(CONTAINER_FRAMES_CONFIG_ADDR, 32'h0000005a, 4'h1);
        wr(CONTAINER_FRAMES_CONFIG_ADDR, 32'h000000ff, 4'h2);
        rd(CONTAINER_FRAMES_CONFIG_ADDR, 32'h5a);
        for (int m = 0; m < 8; m++)
        begin
            wr(MAPPING_FEATURE_CONFIG_ADDR, 32'({m[2], m[1:0], m[1:0]}));
            settle();
            check(32'({narrow, map_mode}), 32'(m[2:0]));
            check(32'(geom), 32'(m[1:0] != 0 && (!m[2] || m[1:0] == 1)));
            check(32'({act_cnt, ovs}), m[1:0] == 0 ? 32'h145 : 32'h0);
            check(32'(cont), m[1:0] == 0 ? 32'h0 : 32'h5a);
            check(32'({rx_sync, tx_sync, rxb_act, txb_act, rxp_act, txp_act}),
                32'({3{m[0], m[1]}}));
        end
        int_clk <= 1'b1;
        settle();
        check(32'({rx_sync, tx_sync, rxp_act, txp_act}), 32'h0);
        int_clk <= 1'b0;
        $display("test modes done");
        wr(RX_BUFFER_FRAME_OFFSET_ADDR, 32'h0001a1b2);
        wr(TX_BUFFER_FRAME_OFFSET_ADDR, 32'h0000c3d4);
        wr(RX_START_PULSE_OFFSET_ADDR, 32'h003fe5f6);
        wr(TX_START_PULSE_OFFSET_ADDR, 32'h01150718);
        settle();
        check(32'({rxb_hf, rxb_off}), 32'h100b2);
        check(32'({txb_hf, txb_off}), 32'h0c3d4);
        check(32'({rxp_hf, rxp_off}), 32'h3fe5f6);
        check(32'({txp_hf, txp_off}), 32'h550018);
        rd(TX_START_PULSE_OFFSET_ADDR, 32'h01150718);
        $display("test offsets done");
        wr(MAPPING_FEATURE_CONFIG_ADDR, 32'hf);
        wr(MAPPING_TABLE_INDEX_ADDR, 32'h5);
        wr(MAPPING_TABLE_RX_ENTRY_ADDR, 32'hea8bf3ff);
        wr(MAPPING_TABLE_TX_ENTRY_ADDR, 32'h13150701);
        wr(MAPPING_TABLE_INDEX_ADDR, 32'h6);
        wr(MAPPING_TABLE_RX_ENTRY_ADDR, 32'h01020300);
        wr(MAPPING_TABLE_INDEX_ADDR, 32'h5);
        rd(MAPPING_TABLE_RX_ENTRY_ADDR, 32'h0a0b1301);
        rd(MAPPING_TABLE_TX_ENTRY_ADDR, 32'h13150701);
        wr(MAPPING_TABLE_INDEX_ADDR, 32'h7ff);
        rd(MAPPING_TABLE_RX_ENTRY_ADDR, ENTRY_MASK);
        @(posedge clk);
        rx_ta <= 11'h6;
        tx_ta <= 11'h5;
        repeat (2) @(posedge clk);
        check(rx_ent, 32'h01020300);
        check(tx_ent, 32'h13150701);
        $display("test table done");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
